// >>> rtl/ppg_defines.svh
// Register offsets, reset values and field positions for the port pair
`ifndef PPG_DEFINES_SVH
`define PPG_DEFINES_SVH
`define PPG_AREA_LAST 6'h3f
`define PPG_OFS_P0_LATCH 6'h00
`define PPG_OFS_P1_LATCH 6'h01
`define PPG_OFS_P0_PIN 6'h08
`define PPG_OFS_P1_DIR 6'h0d
`define PPG_OFS_EXT_IRQ_CTRL 6'h37
`define PPG_IRQ0_SEL_BIT 6
`define PPG_P0_LATCH_RST 8'hff
`define PPG_P1_LATCH_RST 8'h00
`define PPG_P1_DIR_RST 8'h00
`define PPG_EXT_IRQ_RST 8'h00
`endif

// >>> rtl/ppg_pkg.sv
// Types for the parallel port pair
package ppg_pkg;
  // CPU access phase within one bus cycle
  typedef enum logic [1:0] {
    PPG_IDLE = 2'b00,
    PPG_FIRST = 2'b01,
    PPG_SECOND = 2'b10
  } ppg_phase_t;
  // CPU request to the special function area
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ppg_req_t;
  // Whole state of the block
  typedef struct packed {
    ppg_phase_t phase;
    logic is_wr;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] p0_latch;
    logic [7:0] p1_latch;
    logic [7:0] p1_dir;
    logic [7:0] irq_ctrl;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] p0_s1;
    logic [7:0] p0_s2;
    logic [7:0] p1_s1;
    logic [7:0] p1_s2;
  } ppg_state_t;
endpackage

// >>> rtl/ppg_port_pair.sv
// Two 8-bit general-purpose ports in the special function area
`timescale 1ns/1ps
`include "ppg_defines.svh"
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module ppg_port_pair
  import ppg_pkg::*;
(
  input wire logic core_clk, // System clock, 25 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire ppg_req_t cpu_req, // One-cycle request from the CPU
  output logic [7:0] cpu_rdata, // Read data, registered
  output logic cpu_rvalid, // Read data valid pulse
  input wire logic [7:0] port0_pin_in, // Port0 pin levels
  output logic [7:0] port0_pin_out, // Port0 drive levels
  output logic [7:0] port0_pin_oe_n, // Port0 enables, low drives
  input wire logic [7:0] port1_pin_in, // Port1 pin levels
  output logic [7:0] port1_pin_out, // Port1 drive levels
  output logic [7:0] port1_pin_oe_n, // Port1 enables, low drives
  output logic ext_irq0_in, // Interrupt input from port0 bit zero
  output logic ext_irq0_pin_select // Bit zero function select
);
  ppg_state_t st; // Registered state
  ppg_state_t next_st; // Next state

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    // Two-flop synchroniser; first stage feeds only the second
    next_st.p0_s1 = port0_pin_in;
    next_st.p0_s2 = st.p0_s1;
    next_st.p1_s1 = port1_pin_in;
    next_st.p1_s2 = st.p1_s1;
    case (st.phase)
      PPG_IDLE: begin
        // Accept only inside the area; rd wins if both asserted
        // Requests while busy are dropped; the CPU spaces them out
        if ((cpu_req.rd || cpu_req.wr)
            && cpu_req.addr <= `PPG_AREA_LAST) begin
          next_st.phase = PPG_FIRST;
          next_st.is_wr = ~cpu_req.rd;
          next_st.addr = cpu_req.addr;
          next_st.wdata = cpu_req.wdata;
        end
      end
      PPG_FIRST: begin
        next_st.phase = PPG_SECOND;
        if (!st.is_wr) begin
          // Pins sampled now from the second synchroniser flop, nothing held afterwards
          next_st.rvalid = 1'b1;
          if (hit(st.addr, `PPG_OFS_P0_LATCH))
            next_st.rdata = st.p0_latch;
          else if (hit(st.addr, `PPG_OFS_P0_PIN))
            next_st.rdata = st.p0_s2;
          else if (hit(st.addr, `PPG_OFS_P1_LATCH))
            next_st.rdata = (st.p1_dir & st.p1_latch)
                          | (~st.p1_dir & st.p1_s2);
          else if (hit(st.addr, `PPG_OFS_P1_DIR))
            next_st.rdata = st.p1_dir;
          else if (hit(st.addr, `PPG_OFS_EXT_IRQ_CTRL))
            next_st.rdata = st.irq_ctrl;
          else
            next_st.rdata = 8'h00;
        end
      end
      PPG_SECOND: begin
        next_st.phase = PPG_IDLE;
        if (st.is_wr) begin
          // Whole byte lands, so bit ops on port1 copy its input pins in too
          if (hit(st.addr, `PPG_OFS_P0_LATCH))
            next_st.p0_latch = st.wdata;
          if (hit(st.addr, `PPG_OFS_P1_LATCH))
            next_st.p1_latch = st.wdata;
          if (hit(st.addr, `PPG_OFS_P1_DIR))
            next_st.p1_dir = st.wdata;
          if (hit(st.addr, `PPG_OFS_EXT_IRQ_CTRL))
            next_st.irq_ctrl = st.wdata;
          // Pin-input address is read-only: no effect here
        end
      end
      default: next_st.phase = PPG_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  // Synchronous reset loads the power-up value of every latch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.phase <= PPG_IDLE;
      st.p0_latch <= `PPG_P0_LATCH_RST;
      st.p1_latch <= `PPG_P1_LATCH_RST;
      st.p1_dir <= `PPG_P1_DIR_RST;
      st.irq_ctrl <= `PPG_EXT_IRQ_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive: port0 quasi-bidirectional, low pulls, one releases
  // Port0 has no direction register, so inputs need a one in the latch
  // Port1 drives only where its direction bit is one
  always_comb begin
    port0_pin_out = st.p0_latch;
    port0_pin_oe_n = st.p0_latch;
    // Interrupt function keeps bit zero as input
    if (st.irq_ctrl[`PPG_IRQ0_SEL_BIT])
      port0_pin_oe_n[0] = 1'b1;
    port1_pin_out = st.p1_latch;
    port1_pin_oe_n = ~st.p1_dir;
  end

  assign ext_irq0_pin_select = st.irq_ctrl[`PPG_IRQ0_SEL_BIT];
  assign ext_irq0_in = st.irq_ctrl[`PPG_IRQ0_SEL_BIT] & st.p0_s2[0];
  assign cpu_rdata = st.rdata;
  assign cpu_rvalid = st.rvalid;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_p0_reset_ones: assert property (@(posedge core_clk)
    sys_rst |=> port0_pin_out == 8'hff)
    else $error("port0 latch not ones after reset");
  a_p1_reset_in: assert property (@(posedge core_clk)
    sys_rst |=> port1_pin_oe_n == 8'hff && port1_pin_out == 8'h00)
    else $error("port1 not input after reset");
  a_write_second: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_IDLE && cpu_req.wr && !cpu_req.rd
     && cpu_req.addr == `PPG_OFS_P0_LATCH)
    |=> ##2 port0_pin_out == $past(cpu_req.wdata, 3))
    else $error("port0 write not driven in second state");
  a_read_first: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_IDLE && cpu_req.rd) |=> ##1 cpu_rvalid)
    else $error("read answer not after first state");
  a_p0_pin_read: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_FIRST && !st.is_wr && st.addr == `PPG_OFS_P0_PIN)
    |=> cpu_rdata == $past(st.p0_s2))
    else $error("pin input read mismatch");
  a_p1_mixed_read: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_FIRST && !st.is_wr && st.addr == `PPG_OFS_P1_LATCH)
    |=> cpu_rdata == (($past(st.p1_dir) & $past(st.p1_latch))
                    | (~$past(st.p1_dir) & $past(st.p1_s2))))
    else $error("port1 read mix wrong");
  // Direction write lands in the second state, then steers the drivers
  a_dir_drive: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_IDLE && cpu_req.wr && !cpu_req.rd
     && cpu_req.addr == `PPG_OFS_P1_DIR)
    |=> ##2 port1_pin_oe_n == ~$past(cpu_req.wdata, 3))
    else $error("port1 enable not from direction");
  a_irq_sel_in: assert property (@(posedge core_clk)
    disable iff (sys_rst) ext_irq0_pin_select |-> port0_pin_oe_n[0])
    else $error("bit zero driven in interrupt mode");
  // Anything outside the five decoded offsets reads as zero
  a_unmapped_zero: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_FIRST && !st.is_wr
     && st.addr != `PPG_OFS_P0_LATCH && st.addr != `PPG_OFS_P1_LATCH
     && st.addr != `PPG_OFS_P0_PIN && st.addr != `PPG_OFS_P1_DIR
     && st.addr != `PPG_OFS_EXT_IRQ_CTRL)
    |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Port0 latch read returns the latch as it stood in the first state
  a_p0_latch_read: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_FIRST && !st.is_wr && st.addr == `PPG_OFS_P0_LATCH)
    |=> cpu_rdata == $past(port0_pin_out))
    else $error("port0 latch read mismatch");
  // Port1 latch takes any write, whatever the direction bits say
  a_p1_latch_write: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_IDLE && cpu_req.wr && !cpu_req.rd
     && cpu_req.addr == `PPG_OFS_P1_LATCH)
    |=> ##2 port1_pin_out == $past(cpu_req.wdata, 3))
    else $error("port1 latch write lost");
  // A write to the pin-input address must leave both latches alone
  a_ro_write_ignored: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    (st.phase == PPG_IDLE && cpu_req.wr && !cpu_req.rd
     && cpu_req.addr == `PPG_OFS_P0_PIN)
    |=> ##2 port0_pin_out == $past(port0_pin_out, 3)
        && port1_pin_out == $past(port1_pin_out, 3))
    else $error("read-only write changed a latch");
  // Valid is a single-cycle pulse; reads are spaced three cycles apart
  a_rvalid_pulse: assert property (@(posedge core_clk)
    disable iff (sys_rst) cpu_rvalid |=> !cpu_rvalid)
    else $error("read valid held too long");
  // Interrupt input follows the synchronised pin only while selected
  a_irq_follows_pin: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    ext_irq0_in == (ext_irq0_pin_select & $past(port0_pin_in[0], 2)))
    else $error("interrupt input not from pin");
endmodule // ppg_port_pair

// >>> testbench/parallel_port_pair_gpio_bench.sv
// Self-checking bench for the parallel port pair
`timescale 1ns/1ps
module parallel_port_pair_gpio_bench;
  import ppg_pkg::*;
  logic core_clk = 1'b0; // 25 MHz system clock
  logic sys_rst = 1'b1; // Held for 20 cycles
  ppg_req_t cpu_req = '0; // CPU request pulses
  logic [7:0] cpu_rdata, port0_pin_in, port0_pin_out, port0_pin_oe_n;
  logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe_n;
  logic [7:0] ext0 = 8'h00, ext1 = 8'h00, d, e, l0;
  logic cpu_rvalid, ext_irq0_in, ext_irq0_pin_select;
  logic [7:0] exp_q[$]; // Read results still awaited
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 53045; // Fixed seed keeps runs repeatable
  always #20 core_clk = ~core_clk;
  ppg_port_pair i_ppg_port_pair (.core_clk(core_clk), .sys_rst(sys_rst),
    .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .port0_pin_in(port0_pin_in), .port0_pin_out(port0_pin_out),
    .port0_pin_oe_n(port0_pin_oe_n), .port1_pin_in(port1_pin_in),
    .port1_pin_out(port1_pin_out), .port1_pin_oe_n(port1_pin_oe_n),
    .ext_irq0_in(ext_irq0_in), .ext_irq0_pin_select(ext_irq0_pin_select));
  ppg_pin_model i_ppg_pin_model (.ext0(ext0), .ext1(ext1),
    .port0_pin_out(port0_pin_out), .port0_pin_oe_n(port0_pin_oe_n),
    .port1_pin_out(port1_pin_out), .port1_pin_oe_n(port1_pin_oe_n),
    .port0_pin_in(port0_pin_in), .port1_pin_in(port1_pin_in));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One request, then sit out the whole busy window
  task automatic acc(input logic rd, input logic [5:0] a, input logic [7:0] v);
    @(posedge core_clk);
    cpu_req <= '{rd: rd, wr: !rd, addr: a, wdata: v};
    if (rd) exp_q.push_back(v);
    @(posedge core_clk);
    cpu_req <= '0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // New source levels, then time for the two synchroniser flops
  task automatic pins(input logic [7:0] a, b);
    @(posedge core_clk);
    ext0 <= a;
    ext1 <= b;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Read data watcher: oldest note against each valid pulse
  always @(posedge core_clk) begin
    if (!sys_rst && cpu_rvalid === 1'b1) begin
      if (exp_q.size() > 0)
        chk("read data", exp_q.pop_front(), cpu_rdata);
      else chk("stray valid", 8'h00, 8'h01);
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    chk("timeout", 8'h00, 8'h01);
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("p0 out", 8'hff, port0_pin_out);
    chk("p1 oe_n", 8'hff, port1_pin_oe_n);
    acc(1, 6'h00, 8'hff);
    acc(1, 6'h01, 8'h00);
    acc(1, 6'h0d, 8'h00);
    l0 = 8'hff;
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      e = 8'($random(seed));
      pins(d, ~d);
      acc(1, 6'h08, d & l0);
      l0 = d ^ e;
      acc(0, 6'h00, l0);
      chk("p0 out", l0, port0_pin_out);
      chk("p0 oe_n", l0, port0_pin_oe_n);
      acc(1, 6'h00, l0);
      acc(0, 6'h01, d);
      chk("p1 out", d, port1_pin_out);
      acc(0, 6'h0d, e);
      chk("p1 oe_n", ~e, port1_pin_oe_n);
      acc(1, 6'h01, (d & e) | (~d & ~e));
    end
    acc(0, 6'h08, 8'h00);
    acc(1, 6'h00, l0);
    acc(1, 6'h31, 8'h00);
    acc(0, 6'h00, 8'hff);
    acc(0, 6'h37, 8'h40);
    chk("irq select", 8'h01, {7'h00, ext_irq0_pin_select});
    pins(8'h01, 8'h00);
    chk("irq in", 8'h01, {7'h00, ext_irq0_in});
    pins(8'h00, 8'h00);
    chk("irq in low", 8'h00, {7'h00, ext_irq0_in});
    pins(8'h01, 8'h00);
    acc(0, 6'h37, 8'h00);
    chk("irq in", 8'h00, {7'h00, ext_irq0_in});
    acc(0, 6'h01, 8'hff);
    acc(0, 6'h0d, 8'hff);
    chk("p1 out", 8'hff, port1_pin_out);
    chk("p1 oe_n", 8'h00, port1_pin_oe_n);
    acc(0, 6'h0d, 8'h00);
    chk("p1 oe_n", 8'hff, port1_pin_oe_n);
    acc(0, 6'h00, 8'h00);
    chk("p0 out", 8'h00, port0_pin_out);
    // Second reset in mid-run, over latches away from their reset values
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("p0 out", 8'hff, port0_pin_out);
    chk("p1 out", 8'h00, port1_pin_out);
    chk("p1 oe_n", 8'hff, port1_pin_oe_n);
    chk("irq select", 8'h00, {7'h00, ext_irq0_pin_select});
    acc(1, 6'h0d, 8'h00);
    acc(1, 6'h00, 8'hff);
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) @(posedge core_clk);
    if (exp_q.size() > 0) chk("reads lost", 8'h00, 8'h01);
    tally_and_finish();
  end
endmodule // parallel_port_pair_gpio_bench

// >>> testbench/ppg_pin_model.sv
// Behavioural model of the circuitry on both port pin groups
`timescale 1ns/1ps
module ppg_pin_model (
  input wire logic [7:0] ext0, // Source level offered to port0
  input wire logic [7:0] ext1, // Source level offered to port1
  input wire logic [7:0] port0_pin_out,
  input wire logic [7:0] port0_pin_oe_n,
  input wire logic [7:0] port1_pin_out,
  input wire logic [7:0] port1_pin_oe_n,
  output logic [7:0] port0_pin_in,
  output logic [7:0] port1_pin_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Driven bits show the device level, released bits the source level;
  // the source holds steady since the device does not latch inputs
  assign port0_pin_in = (port0_pin_oe_n & ext0) |
    (~port0_pin_oe_n & port0_pin_out);
  assign port1_pin_in = (port1_pin_oe_n & ext1) |
    (~port1_pin_oe_n & port1_pin_out);
endmodule // ppg_pin_model
